// file: design/prp_pkg.sv
package prp_pkg;
  // timing, 100 MHz system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_TIME_NS = 200;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_RESET_NS = 1000;
  localparam int MIN_RESET_CYCLES = (MIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MDC_MAX_MHZ = 25;
  localparam int REF_PERIOD_NS = 40;
  localparam int REF_CYCLES = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REF_TOL_CYCLES = 1;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] REF_LO = CNT_W'(REF_CYCLES - REF_TOL_CYCLES);
  localparam logic [CNT_W-1:0] REF_HI = CNT_W'(REF_CYCLES + REF_TOL_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  // reset values
  localparam logic PIN_ROLE_RST = 1'b0;

  typedef enum logic [1:0] {PS_INIT, PS_RUN, PS_DOWN} prp_state_type;

  typedef struct packed {
    logic wake;
    logic sleep;
    logic irq_role;
    logic pdn_role;
  } prp_mgmt_req_type;

  typedef struct packed {
    logic powered_down;
    logic core_rst_n;
    logic core_clk_en;
    logic mgmt_ready;
    logic ref_ok;
    logic irq_role;
  } prp_status_type;
endpackage : prp_pkg

// file: design/prp_top.sv
`timescale 1ns/1ps
module prp_top import prp_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic irq_or_sleep_pin_i,
  output logic irq_or_sleep_pin_o,
  output logic irq_or_sleep_pin_oe,
  input wire logic irq_event,
  input wire logic irq_ack,
  input wire prp_mgmt_req_type mgmt_req,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic mdio_drv_en,
  input wire logic mdio_drv_bit,
  output logic mdio_bit,
  output logic mdio_bit_stb,
  input wire logic ref_osc_in,
  output prp_status_type status
);

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction : rise

  // power state group
  prp_state_type state_q, state_d;
  logic [CNT_W-1:0] init_cnt_q, init_cnt_d;
  logic role_q, role_d;
  logic sleep_q, sleep_d;
  logic pdn_req;

  always_comb begin
    role_d = role_q;
    sleep_d = sleep_q;
    if (mgmt_req.irq_role) begin
      role_d = 1'b1;
    end else if (mgmt_req.pdn_role) begin
      role_d = PIN_ROLE_RST;
    end
    // management commands act in every power state
    if (mgmt_req.sleep) begin
      sleep_d = 1'b1;
    end else if (mgmt_req.wake) begin
      sleep_d = 1'b0;
    end
    // pin only counts as power-down request in its input role
    pdn_req = (~role_q & ~irq_or_sleep_pin_i) | sleep_q;
    state_d = state_q;
    init_cnt_d = init_cnt_q;
    unique case (state_q)
      PS_INIT: begin
        init_cnt_d = init_cnt_q + CNT_ONE;
        if (init_cnt_q == INIT_LAST) begin
          state_d = PS_RUN;
          init_cnt_d = '0;
        end
      end
      PS_RUN: begin
        if (pdn_req) begin
          state_d = PS_DOWN;
        end
      end
      PS_DOWN: begin
        if (!pdn_req) begin
          state_d = PS_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PS_INIT;
      init_cnt_q <= '0;
      role_q <= PIN_ROLE_RST;
      sleep_q <= 1'b0;
    end else begin
      state_q <= state_d;
      init_cnt_q <= init_cnt_d;
      role_q <= role_d;
      sleep_q <= sleep_d;
    end
  end

  // interrupt pin group
  logic irq_pend_q, irq_pend_d;
  logic pin_oe_q, pin_oe_d;

  always_comb begin
    // a new event in the ack cycle is kept
    irq_pend_d = irq_event | (irq_pend_q & ~irq_ack);
    pin_oe_d = role_d & irq_pend_d;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_pend_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      irq_pend_q <= irq_pend_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // open drain: level is never driven high
  assign irq_or_sleep_pin_o = 1'b0;
  assign irq_or_sleep_pin_oe = pin_oe_q;

  // management serial group, kept out of power gating
  logic mdc_q, mdc_d;
  logic mdio_bit_q, mdio_bit_d;
  logic mdio_stb_q, mdio_stb_d;
  logic mdio_o_q, mdio_o_d;
  logic mdio_oe_q, mdio_oe_d;

  always_comb begin
    mdc_d = mdc;
    mdio_bit_d = mdio_bit_q;
    mdio_stb_d = rise(mdc, mdc_q);
    mdio_o_d = mdio_o_q;
    mdio_oe_d = mdio_oe_q;
    if (rise(mdc, mdc_q)) begin
      mdio_bit_d = mdio_i;
    end
    // drive changes on falling edge so station samples on rising
    if (rise(mdc_q, mdc)) begin
      mdio_o_d = mdio_drv_bit;
      mdio_oe_d = mdio_drv_en;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mdc_q <= 1'b0;
      mdio_bit_q <= 1'b0;
      mdio_stb_q <= 1'b0;
      mdio_o_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      mdc_q <= mdc_d;
      mdio_bit_q <= mdio_bit_d;
      mdio_stb_q <= mdio_stb_d;
      mdio_o_q <= mdio_o_d;
      mdio_oe_q <= mdio_oe_d;
    end
  end

  assign mdio_bit = mdio_bit_q;
  assign mdio_bit_stb = mdio_stb_q;
  assign mdio_o = mdio_o_q;
  assign mdio_oe = mdio_oe_q;

  // reference clock monitor: only catches gross faults at 100 MHz sampling
  logic ref_q, ref_d;
  logic [CNT_W-1:0] per_q, per_d;
  logic ref_ok_q, ref_ok_d;

  always_comb begin
    ref_d = ref_osc_in;
    per_d = (per_q == CNT_MAX) ? per_q : per_q + CNT_ONE;
    ref_ok_d = ref_ok_q;
    if (rise(ref_osc_in, ref_q)) begin
      ref_ok_d = (per_q >= REF_LO) && (per_q <= REF_HI);
      per_d = CNT_ONE;
    end else if (per_q > REF_HI) begin
      ref_ok_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q <= 1'b0;
      per_q <= '0;
      ref_ok_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      per_q <= per_d;
      ref_ok_q <= ref_ok_d;
    end
  end

  // status register
  prp_status_type stat_q, stat_d;

  always_comb begin
    stat_d.powered_down = (state_d == PS_DOWN);
    stat_d.core_rst_n = (state_d != PS_INIT);
    stat_d.core_clk_en = (state_d == PS_RUN);
    stat_d.mgmt_ready = 1'b1;
    stat_d.ref_ok = ref_ok_d;
    stat_d.irq_role = role_d;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign status = stat_q;

  // checks
  property p_role_default;
    @(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> !status.irq_role;
  endproperty
  a_role_default: assert property (p_role_default) else $error("pin role not default");

  property p_pin_pdn;
    @(posedge clk) disable iff (!nrst)
    (state_q == PS_RUN && !role_q && !irq_or_sleep_pin_i) |=> status.powered_down;
  endproperty
  a_pin_pdn: assert property (p_pin_pdn) else $error("pin low did not power down");

  property p_pdn_clk_off;
    @(posedge clk) disable iff (!nrst)
    status.powered_down |-> ($past(pdn_req) && !status.core_clk_en);
  endproperty
  a_pdn_clk_off: assert property (p_pdn_clk_off) else $error("power-down state wrong");

  property p_mgmt_in_pdn;
    @(posedge clk) disable iff (!nrst)
    (status.powered_down && mdc && !mdc_q) |=> (mdio_bit_stb && status.mgmt_ready);
  endproperty
  a_mgmt_in_pdn: assert property (p_mgmt_in_pdn) else $error("management lost in power-down");

  property p_wake;
    @(posedge clk) disable iff (!nrst)
    (status.powered_down && role_q && mgmt_req.wake && !mgmt_req.sleep && !mgmt_req.pdn_role)
    |-> ##2 !status.powered_down;
  endproperty
  a_wake: assert property (p_wake) else $error("wake command ignored");

  property p_open_drain;
    @(posedge clk) disable iff (!nrst)
    irq_or_sleep_pin_oe |-> (status.irq_role && !irq_or_sleep_pin_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven outside irq role");

  property p_irq_hold;
    @(posedge clk) disable iff (!nrst)
    (role_q && !mgmt_req.pdn_role && irq_event) |=> irq_or_sleep_pin_oe;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("event did not pull pin low");

  property p_init_len;
    @(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> !status.core_rst_n [*8];
  endproperty
  a_init_len: assert property (p_init_len) else $error("core reset released too early");

  property p_mdio_drive;
    @(posedge clk) disable iff (!nrst)
    (mdc_q && !mdc) |=> (mdio_o == $past(mdio_drv_bit) && mdio_oe == $past(mdio_drv_en));
  endproperty
  a_mdio_drive: assert property (p_mdio_drive) else $error("mdio not driven on clock fall");

  c_pdn_cycle: cover property (@(posedge clk) disable iff (!nrst)
    status.powered_down ##[1:50] !status.powered_down);
  c_irq_pull: cover property (@(posedge clk) disable iff (!nrst)
    status.irq_role && irq_or_sleep_pin_oe);
  c_ref_ok: cover property (@(posedge clk) disable iff (!nrst) $rose(status.ref_ok));

endmodule : prp_top

// file: bench/prp_station.sv
`timescale 1ns/1ps
module prp_station (
  input wire logic clk,
  input wire logic run,
  output logic mdc,
  output logic st_bit,
  output logic ref_osc_in
);
  logic [1:0] ph;
  logic [1:0] c;
  initial begin
    {mdc, st_bit, ref_osc_in, ph, c} = 7'h00;
  end
  // 4 clk period, 25 MHz reference
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    ref_osc_in <= ph[1];
  end
  // mdc stops low between frames; 6 clk period keeps under the limit
  always @(negedge clk) begin
    c <= (c == 2'h2) ? 2'h0 : c + 2'h1;
    if (c == 2'h2 && (run || mdc)) begin
      mdc <= ~mdc;
      if (mdc) st_bit <= 1'($urandom_range(1));
    end
  end
endmodule : prp_station

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench import prp_pkg::*; ();
  logic clk = 0, nrst = 0, host_low = 0, irq_event = 0, irq_ack = 0;
  logic drv_en = 0, drv_bit = 0, run = 0, e;
  prp_mgmt_req_type req = '0;
  logic pin_o, pin_oe, mdio_o, mdio_oe, mdio_bit, stb, mdc, st_bit, ref_osc;
  prp_status_type st;
  int error_cnt = 0, samples_checked = 0;
  int rise_n = 0, stb_n = 0;
  logic mdio_w_q;
  // released lines go to their pull-ups
  wire mdio_w = mdio_oe ? mdio_o : (run ? st_bit : 1'b1);
  wire pin_w = ~(pin_oe | host_low);
  always #5 clk = ~clk;
  prp_station u_st (.clk(clk), .run(run), .mdc(mdc), .st_bit(st_bit), .ref_osc_in(ref_osc));
  prp_top uut (.clk(clk), .nrst(nrst), .irq_or_sleep_pin_i(pin_w),
    .irq_or_sleep_pin_o(pin_o), .irq_or_sleep_pin_oe(pin_oe), .irq_event(irq_event),
    .irq_ack(irq_ack), .mgmt_req(req), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdio_drv_en(drv_en), .mdio_drv_bit(drv_bit), .mdio_bit(mdio_bit),
    .mdio_bit_stb(stb), .ref_osc_in(ref_osc), .status(st));
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  function automatic logic [5:0] exp_st(input logic pd, input logic role);
    return {pd, 1'b1, ~pd, 1'b1, 1'b1, role};
  endfunction : exp_st
  task automatic pulse(input prp_mgmt_req_type r);
    req = r;
    cyc(1);
    req = '0;
    cyc(2);
  endtask : pulse
  // captured bit must match the line at the mdc rise
  always @(posedge clk) begin
    mdio_w_q <= mdio_w;
  end
  always @(posedge mdc) begin
    rise_n++;
  end
  // compare off the edge, against the line as the design sampled it
  always @(negedge clk) begin
    if (stb === 1'b1) begin
      stb_n++;
      chk(mdio_bit, mdio_w_q);
    end
  end
  initial begin
    #20us;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(18214));
    repeat (2) begin
      cyc(MIN_RESET_CYCLES);
      chk(st, 6'h00);
      chk(pin_oe, 6'h00);
      nrst = 1;
      cyc(INIT_CYCLES + 4);
      chk(st, exp_st(0, 0));
      host_low = 1;
      cyc(2);
      chk(st, exp_st(1, 0));
      run = 1;
      cyc(30);
      drv_en = 1;
      drv_bit = 1'($urandom_range(1));
      cyc(30);
      chk({mdio_oe, mdio_o}, {drv_en, drv_bit});
      {run, drv_en, host_low} = 3'h0;
      cyc(12);
      chk(st, exp_st(0, 0));
      chk(6'(stb_n), 6'(rise_n));
      irq_event = 1;
      cyc(1);
      irq_event = 0;
      cyc(2);
      chk(pin_oe, 6'h00);
      pulse(4'h2);
      chk({pin_oe, pin_o}, 6'h02);
      chk(st, exp_st(0, 1));
      repeat (8) begin
        e = 1'($urandom_range(1));
        irq_event = e;
        irq_ack = 1;
        cyc(1);
        {irq_event, irq_ack} = 2'h0;
        chk(pin_oe, e);
        cyc(1);
      end
      irq_ack = 1;
      cyc(1);
      irq_ack = 0;
      cyc(1);
      chk(pin_oe, 6'h00);
      pulse(4'h4);
      chk(st, exp_st(1, 1));
      pulse(4'h8);
      chk(st, exp_st(0, 1));
      pulse(4'h1);
      chk(st, exp_st(0, 0));
      irq_event = 1;
      cyc(1);
      irq_event = 0;
      nrst = 0;
      cyc(1);
    end
    stop_test();
  end
endmodule : testbench
